/* File: hw/gst_pkg.sv */
package gst_pkg;

    // -----------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // -----------------------------------------------------------------
    localparam logic [11:0] GST_ADDR_CONTROL   = 12'h010;
    localparam logic [11:0] GST_ADDR_COUNT_LOW = 12'h020;
    localparam logic [11:0] GST_ADDR_COUNT_HI  = 12'h024;
    localparam logic [11:0] GST_ADDR_FLAGS     = 12'h028;
    localparam logic [11:0] GST_ADDR_ENABLES   = 12'h02C;

    // -----------------------------------------------------------------
    // control register fields
    // -----------------------------------------------------------------
    localparam int GST_CTL_RUN      = 0;
    localparam int GST_CTL_CLKSRC   = 1;
    localparam int GST_CTL_NOSYNC   = 2;
    localparam int GST_CTL_OSCEN    = 3;
    localparam int GST_CTL_PS_LO    = 4;
    localparam int GST_CTL_PS_HI    = 5;
    localparam int GST_CTL_GATE_EN  = 6;
    localparam int GST_CTL_GATE_INV = 7;
    localparam logic [7:0] GST_CONTROL_RESET = 8'h00;

    // -----------------------------------------------------------------
    // flag and enable register fields
    // -----------------------------------------------------------------
    localparam int GST_FLG_OVF      = 0;
    localparam int GST_EN_OVF       = 0;
    localparam int GST_EN_GATE_SRC  = 1;
    localparam int GST_EN_PERIPH    = 6;
    localparam int GST_EN_GLOBAL    = 7;
    localparam logic [7:0] GST_ENABLES_RESET = 8'h00;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int GST_CLK_PER_INSTR = 4;
    localparam int GST_SYNC_STAGES   = 3;

    typedef enum logic [1:0] {
        GST_EDGE_ARM  = 2'b01,
        GST_EDGE_LIVE = 2'b10
    } gst_edge_type;

endpackage

/* File: hw/gst_prescaler.sv */
`timescale 1ns/100ps
// divide-by 1/2/4/8 of a tick stream; cleared by count writes
module gst_prescaler
    import gst_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic [1:0] ratio_sel,
    input  wire logic       clear,
    // ticks
    input  wire logic       tick_in,
    output logic            tick_out
);

    logic [2:0] pre_q;
    logic [2:0] pre_d;
    logic [2:0] limit;

    // -----------------------------------------------------------------
    // prescale counter
    // -----------------------------------------------------------------
    // 00 passes every tick, 11 passes one in eight
    always_comb begin
        limit    = 3'((4'h1 << ratio_sel) - 4'h1);
        pre_d    = pre_q;
        tick_out = 1'b0;
        if (clear) begin
            pre_d = 3'h0;
        end else if (tick_in) begin
            if (pre_q >= limit) begin
                pre_d    = 3'h0;
                tick_out = 1'b1;
            end else begin
                pre_d = pre_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q <= 3'h0;
        end else begin
            pre_q <= pre_d;
        end
    end

endmodule

/* File: hw/gst_sync.sv */
`timescale 1ns/100ps
// three-stage synchroniser; output changes once stages two and three agree
module gst_sync
    import gst_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // data
    input  wire logic din,
    output logic      dout
);

    logic [GST_SYNC_STAGES-1:0] stage_q;
    logic [GST_SYNC_STAGES-1:0] stage_d;
    logic                       out_q;
    logic                       out_d;

    // -----------------------------------------------------------------
    // shift and agree
    // -----------------------------------------------------------------
    // stage 0 feeds stage 1 only, never the agree logic
    always_comb begin
        stage_d = {stage_q[GST_SYNC_STAGES-2:0], din};
        out_d   = out_q;
        if (stage_q[1] == stage_q[2]) begin
            out_d = stage_q[2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_q <= '0;
            out_q   <= 1'b0;
        end else begin
            stage_q <= stage_d;
            out_q   <= out_d;
        end
    end

    assign dout = out_q;

endmodule

/* File: hw/gst_timer.sv */
// Our own choice: the APB slave port.
`timescale 1ns/100ps
// How it works
// - sixteen-bit count, two bytes read/write
// - rollover wraps to zero, sets overflow flag
// - request needs overflow, peripheral, global enables
// - timer mode counts each instruction cycle
// - counter mode counts external rising edges
// - external clock synchronised or not, selectable
// - falling edge must precede first counted rise
// - prescaler divides by 1, 2, 4, 8
// - prescaler hidden; count writes clear it
// - gate from pin or comparator two
// - gating only when gate enable set
// - gate invert flips either gate source
// - asynchronous overflow wakes the processor
// - low-power crystal may clock the counter
// - control register layout, resets to zero
// - prescale code 00..11 means 1:1..1:8
// - sync disable counts without synchronisation
// - asynchronous mode keeps counting during sleep
module gst_timer
    import gst_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // external inputs
    input  wire logic        EXT_CLOCK_IN,
    input  wire logic        CRYSTAL_CLOCK_IN,
    input  wire logic        GATE_PIN,
    input  wire logic        COMPARATOR_TWO_OUTPUT,
    // processor status
    input  wire logic        CPU_SLEEP,
    // outputs
    output logic             IRQ,
    output logic             WAKEUP,
    output logic             CRYSTAL_OSC_ENABLE
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [7:0]   control_q, control_d;
    logic [7:0]   enables_q, enables_d;
    logic [15:0]  count_q, count_d;
    logic         flag_q, flag_d;
    logic         wake_q, wake_d;
    logic [1:0]   instr_q, instr_d;
    logic         ext_prev_q, ext_prev_d;
    logic         pend_q, pend_d;
    gst_edge_type edge_q, edge_d;

    // -----------------------------------------------------------------
    // pin synchronisers and source choice
    // -----------------------------------------------------------------
    logic ext_sync, xtal_sync, gate_pin_sync, cmp_sync;
    logic ext_level, gate_raw, gate_ok;

    gst_sync u_sync_ext  (.clk(CLK), .rst(RST), .din(EXT_CLOCK_IN),          .dout(ext_sync));
    gst_sync u_sync_xtal (.clk(CLK), .rst(RST), .din(CRYSTAL_CLOCK_IN),      .dout(xtal_sync));
    gst_sync u_sync_gate (.clk(CLK), .rst(RST), .din(GATE_PIN),              .dout(gate_pin_sync));
    gst_sync u_sync_cmp  (.clk(CLK), .rst(RST), .din(COMPARATOR_TWO_OUTPUT), .dout(cmp_sync));

    // crystal replaces the pin when the oscillator is enabled
    assign ext_level = control_q[GST_CTL_OSCEN] ? xtal_sync : ext_sync;
    assign gate_raw  = enables_q[GST_EN_GATE_SRC] ? cmp_sync : gate_pin_sync;
    // gate passes unless enabled and inactive after inversion
    assign gate_ok   = !control_q[GST_CTL_GATE_EN]
                     || (gate_raw ^ control_q[GST_CTL_GATE_INV]);
    assign CRYSTAL_OSC_ENABLE = control_q[GST_CTL_OSCEN]
                              && control_q[GST_CTL_CLKSRC];

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    logic bus_wr, bus_rd, addr_ok, wr_low, wr_high, wr_any_count;

    assign PREADY  = 1'b1;
    assign addr_ok = (PADDR == GST_ADDR_CONTROL) || (PADDR == GST_ADDR_COUNT_LOW)
                   || (PADDR == GST_ADDR_COUNT_HI) || (PADDR == GST_ADDR_FLAGS)
                   || (PADDR == GST_ADDR_ENABLES);
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign bus_wr  = PSEL && PENABLE && PWRITE && PSTRB[0];
    assign bus_rd  = PSEL && !PENABLE && !PWRITE;
    assign wr_low  = bus_wr && (PADDR == GST_ADDR_COUNT_LOW);
    assign wr_high = bus_wr && (PADDR == GST_ADDR_COUNT_HI);
    assign wr_any_count = wr_low || wr_high;

    // -----------------------------------------------------------------
    // tick generation
    // -----------------------------------------------------------------
    logic rise, fall, raw_tick, gated_tick, pre_tick, asynch;

    // async mode skips the instruction-phase alignment
    assign asynch = control_q[GST_CTL_CLKSRC] && control_q[GST_CTL_NOSYNC];
    assign rise   = ext_level && !ext_prev_q;
    assign fall   = !ext_level && ext_prev_q;

    // external path: armed state needs a falling edge first
    always_comb begin
        ext_prev_d = ext_level;
        pend_d     = pend_q;
        instr_d    = 2'(instr_q + 2'h1);
        edge_d     = edge_q;
        if (!control_q[GST_CTL_RUN] || !control_q[GST_CTL_CLKSRC]) begin
            edge_d = GST_EDGE_ARM;
        end else if (fall) begin
            edge_d = GST_EDGE_LIVE;
        end
        raw_tick = 1'b0;
        if (control_q[GST_CTL_CLKSRC]) begin
            if (asynch) begin
                raw_tick = rise && (edge_q == GST_EDGE_LIVE);
            end else begin
                // a rise waits in pend until the instruction boundary
                pend_d   = pend_q || (rise && (edge_q == GST_EDGE_LIVE));
                raw_tick = pend_d && (instr_q == 2'(GST_CLK_PER_INSTR - 1));
                if (raw_tick) begin
                    pend_d = 1'b0;
                end
            end
        end else begin
            raw_tick = (instr_q == 2'(GST_CLK_PER_INSTR - 1));
        end
        if (!control_q[GST_CTL_RUN] || !control_q[GST_CTL_CLKSRC]) begin
            pend_d = 1'b0;
        end
    end

    // run and gate both hold count and prescaler
    assign gated_tick = raw_tick && control_q[GST_CTL_RUN] && gate_ok;

    gst_prescaler u_pre (
        .clk      (CLK),
        .rst      (RST),
        .ratio_sel(control_q[GST_CTL_PS_HI:GST_CTL_PS_LO]),
        .clear    (wr_any_count),
        .tick_in  (gated_tick),
        .tick_out (pre_tick)
    );

    // note: only one rise is held per instruction cycle;
    // keep the external rate well under a quarter of clk

    // -----------------------------------------------------------------
    // count, flag and registers
    // -----------------------------------------------------------------
    logic rollover;

    assign rollover = pre_tick && (count_q == 16'hFFFF);

    always_comb begin
        control_d = control_q;
        enables_d = enables_q;
        count_d   = count_q;
        flag_d    = flag_q;
        wake_d    = 1'b0;
        if (pre_tick) begin
            count_d = 16'(count_q + 16'h0001);
        end
        // software write of a byte wins over a tick in the same cycle
        if (wr_low) begin
            count_d[7:0] = PWDATA[7:0];
        end
        if (wr_high) begin
            count_d[15:8] = PWDATA[7:0];
        end
        if (bus_wr && PADDR == GST_ADDR_CONTROL) begin
            control_d = PWDATA[7:0];
        end
        if (bus_wr && PADDR == GST_ADDR_ENABLES) begin
            enables_d = PWDATA[7:0];
        end
        // software writes zero to clear; hardware set wins
        if (bus_wr && PADDR == GST_ADDR_FLAGS && !PWDATA[GST_FLG_OVF]) begin
            flag_d = 1'b0;
        end
        if (rollover) begin
            flag_d = 1'b1;
            wake_d = asynch && CPU_SLEEP;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            control_q  <= GST_CONTROL_RESET;
            enables_q  <= GST_ENABLES_RESET;
            count_q    <= 16'h0000;
            flag_q     <= 1'b0;
            wake_q     <= 1'b0;
            instr_q    <= 2'h0;
            ext_prev_q <= 1'b0;
            pend_q     <= 1'b0;
            edge_q     <= GST_EDGE_ARM;
        end else begin
            control_q  <= control_d;
            enables_q  <= enables_d;
            count_q    <= count_d;
            flag_q     <= flag_d;
            wake_q     <= wake_d;
            instr_q    <= instr_d;
            ext_prev_q <= ext_prev_d;
            pend_q     <= pend_d;
            edge_q     <= edge_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // read data latched in the setup cycle, shown in the access cycle
    always_comb begin
        rdata_d = rdata_q;
        if (bus_rd) begin
            unique case (PADDR)
                GST_ADDR_CONTROL:   rdata_d = {24'h000000, control_q};
                GST_ADDR_COUNT_LOW: rdata_d = {24'h000000, count_q[7:0]};
                GST_ADDR_COUNT_HI:  rdata_d = {24'h000000, count_q[15:8]};
                GST_ADDR_FLAGS:     rdata_d = {31'h00000000, flag_q};
                GST_ADDR_ENABLES:   rdata_d = {24'h000000, enables_q};
                default:            rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign PRDATA = rdata_q;
    // all three enables must be set for a request
    assign IRQ    = flag_q && enables_q[GST_EN_OVF] && enables_q[GST_EN_PERIPH]
                  && enables_q[GST_EN_GLOBAL];
    assign WAKEUP = wake_q;

endmodule

/* File: tb/gst_ext_src.sv */
`timescale 1ns/100ps
// ------------------------------------
// far side: count clock, crystal, gate
// ------------------------------------
module gst_ext_src (
    // clock pins
    output logic ext_clk,
    output logic xtal_clk,
    // gate sources
    output logic gate,
    output logic cmp
);
    logic use_xtal;
    // pins rest low; clocks stand still between bursts
    initial begin
        ext_clk  = 1'b0;
        xtal_clk = 1'b0;
        gate     = 1'b0;
        cmp      = 1'b0;
        use_xtal = 1'b0;
    end
    // 317 ns halves stay under an eighth of the system clock and drift
    // against it, so edges land in every instruction slot
    task automatic pulses(input int n, input int slow);
        for (int i = 0; i < n; i++) begin
            #(317 * slow);
            if (use_xtal) begin
                xtal_clk = 1'b1;
            end else begin
                ext_clk = 1'b1;
            end
            #(317 * slow);
            ext_clk  = 1'b0;
            xtal_clk = 1'b0;
        end
        // let the last rise pass the synchroniser and the slot wait
        #1000;
    endtask
endmodule

/* File: tb/gst_props.sv */
`timescale 1ns/100ps
// ------------
// port checker
// ------------
module gst_props
    import gst_pkg::*;
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // apb
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // status
    input wire logic        CPU_SLEEP,
    input wire logic        IRQ,
    input wire logic        WAKEUP,
    input wire logic        CRYSTAL_OSC_ENABLE
);
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] en_q;
    logic [7:0] en_d;
    logic       acc;
    logic       rd;
    logic       wr;
    logic       map;
    logic       ien;
    // shadows of the control and enables registers, built from bus writes only
    assign acc = PSEL & PENABLE;
    assign rd  = acc & ~PWRITE;
    assign wr  = acc & PWRITE & PSTRB[0];
    assign map = PADDR inside {GST_ADDR_CONTROL, GST_ADDR_COUNT_LOW,
                               GST_ADDR_COUNT_HI, GST_ADDR_FLAGS, GST_ADDR_ENABLES};
    assign ien = en_q[GST_EN_OVF] & en_q[GST_EN_PERIPH] & en_q[GST_EN_GLOBAL];
    always_comb begin
        ctl_d = ctl_q;
        en_d  = en_q;
        if (wr && PADDR == GST_ADDR_CONTROL) begin
            ctl_d = PWDATA[7:0];
        end
        if (wr && PADDR == GST_ADDR_ENABLES) begin
            en_d = PWDATA[7:0];
        end
    end
    always_ff @(posedge CLK) begin
        ctl_q <= RST ? 8'h00 : ctl_d;
        en_q  <= RST ? 8'h00 : en_d;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    AST_READY: assert property (PSEL |-> PREADY)
        else $error("pready low in a transfer");
    AST_ERR: assert property (acc |-> PSLVERR == !map)
        else $error("pslverr disagrees with map");
    AST_UNMAP: assert property (rd && !map |-> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_CTL: assert property (rd && PADDR == GST_ADDR_CONTROL |-> PRDATA[7:0] == ctl_q)
        else $error("control readback wrong");
    AST_ENR: assert property (rd && PADDR == GST_ADDR_ENABLES |-> PRDATA[7:0] == en_q)
        else $error("enables readback wrong");
    AST_IRQM: assert property (IRQ |-> ien)
        else $error("irq without all enables");
    AST_IRQF: assert property (rd && PADDR == GST_ADDR_FLAGS && ien
        |-> IRQ == PRDATA[GST_FLG_OVF]) else $error("irq differs from flag");
    AST_OSC: assert property (CRYSTAL_OSC_ENABLE
        == (ctl_q[GST_CTL_OSCEN] & ctl_q[GST_CTL_CLKSRC])) else $error("osc enable wrong");
    AST_WAKE: assert property (WAKEUP
        |-> $past(ctl_q[GST_CTL_CLKSRC] & ctl_q[GST_CTL_NOSYNC] & CPU_SLEEP))
        else $error("wakeup outside async sleep");
    AST_PULSE: assert property (WAKEUP |=> !WAKEUP)
        else $error("wakeup longer than a cycle");
endmodule

bind gst_timer gst_props u_props (
    .CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
    .PREADY, .PSLVERR, .CPU_SLEEP, .IRQ, .WAKEUP, .CRYSTAL_OSC_ENABLE
);

/* File: tb/gst_timer_bench.sv */
`timescale 1ns/100ps
module gst_timer_bench
    import gst_pkg::*;
();
    // -----------------
    // signals and parts
    // -----------------
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        serr;
    logic        sleep;
    logic        irq;
    logic        wakeup;
    logic        osc;
    logic        ext_clk;
    logic        xtal_clk;
    logic        gate;
    logic        cmp;
    logic [31:0] rd;
    logic [31:0] v;
    int          error_cnt;
    int          n_compared;
    int          wakes;
    gst_timer dut (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_CLOCK_IN(ext_clk),
        .CRYSTAL_CLOCK_IN(xtal_clk), .GATE_PIN(gate), .COMPARATOR_TWO_OUTPUT(cmp),
        .CPU_SLEEP(sleep), .IRQ(irq), .WAKEUP(wakeup), .CRYSTAL_OSC_ENABLE(osc)
    );
    gst_ext_src src (.ext_clk, .xtal_clk, .gate, .cmp);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // wake pulses are one cycle wide, so count them as they pass
    always @(posedge clk) begin
        if (wakeup === 1'b1) wakes <= wakes + 1;
    end
    // --------------
    // shared helpers
    // --------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // never assumes a latency: the access phase lasts until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 1, pready);
        rd = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(nm, e, rd);
    endtask
    task automatic ci(input string nm, input logic e);
        @(negedge clk);
        chk(nm, e, irq);
    endtask
    // ---------
    // scenarios
    // ---------
    task automatic t_regs;
        rchk("ctl rst", GST_ADDR_CONTROL, 0);
        rchk("en rst", GST_ADDR_ENABLES, 0);
        rchk("flag rst", GST_ADDR_FLAGS, 0);
        wr(GST_ADDR_CONTROL, 8'hF4);
        rchk("ctl rw", GST_ADDR_CONTROL, 32'h000000F4);
        wr(GST_ADDR_COUNT_HI, 8'hA5);
        rchk("cnt hi", GST_ADDR_COUNT_HI, 32'h000000A5);
        rchk("unmapped", 12'h030, 0);
        chk("slverr", 1, serr);
        wr(GST_ADDR_CONTROL, 8'h00);
        $display("t_regs done");
    endtask
    // window of 10 prescaled ticks; the slot phase leaves one tick of slack
    task automatic t_timer;
        for (int p = 0; p < 4; p++) begin
            wr(GST_ADDR_COUNT_LOW, 8'h00);
            wr(GST_ADDR_COUNT_HI, 8'h00);
            wr(GST_ADDR_CONTROL, {2'b00, 2'(p), 4'h1});
            repeat (40 * (1 << p) - 3) @(posedge clk);
            wr(GST_ADDR_CONTROL, 8'h00);
            apb(1'b0, GST_ADDR_COUNT_LOW, 8'h00);
            chk("ticks", 1, (rd == 9 || rd == 10));
            v = rd;
            repeat (20) @(posedge clk);
            rchk("hold", GST_ADDR_COUNT_LOW, v);
        end
        $display("t_timer done");
    endtask
    task automatic t_ovf;
        wr(GST_ADDR_COUNT_LOW, 8'hFE);
        wr(GST_ADDR_COUNT_HI, 8'hFF);
        wr(GST_ADDR_FLAGS, 8'h00);
        wr(GST_ADDR_ENABLES, 8'hC1);
        ci("irq idle", 0);
        wr(GST_ADDR_CONTROL, 8'h01);
        repeat (12) @(posedge clk);
        wr(GST_ADDR_CONTROL, 8'h00);
        rchk("wrap hi", GST_ADDR_COUNT_HI, 0);
        rchk("flag", GST_ADDR_FLAGS, 1);
        ci("irq on", 1);
        wr(GST_ADDR_ENABLES, 8'h81);
        ci("irq peri", 0);
        wr(GST_ADDR_ENABLES, 8'h41);
        ci("irq glob", 0);
        wr(GST_ADDR_ENABLES, 8'hC1);
        rchk("sticky", GST_ADDR_FLAGS, 1);
        wr(GST_ADDR_FLAGS, 8'h00);
        ci("irq clr", 0);
        wr(GST_ADDR_ENABLES, 8'h00);
        $display("t_ovf done");
    endtask
    task automatic t_ext;
        wr(GST_ADDR_COUNT_LOW, 8'h00);
        wr(GST_ADDR_CONTROL, 8'h02);
        src.pulses(3, 1);
        rchk("stopped", GST_ADDR_COUNT_LOW, 0);
        wr(GST_ADDR_CONTROL, 8'h00);
        wr(GST_ADDR_CONTROL, 8'h03);
        src.pulses(5, 1);
        rchk("sync", GST_ADDR_COUNT_LOW, 4);
        wr(GST_ADDR_CONTROL, 8'h07);
        src.pulses(3, 2);
        rchk("async", GST_ADDR_COUNT_LOW, 7);
        wr(GST_ADDR_CONTROL, 8'h47);
        src.pulses(3, 1);
        rchk("gated", GST_ADDR_COUNT_LOW, 7);
        wr(GST_ADDR_CONTROL, 8'hC7);
        src.pulses(3, 1);
        rchk("inverted", GST_ADDR_COUNT_LOW, 10);
        src.cmp <= 1'b1;
        wr(GST_ADDR_ENABLES, 8'h02);
        wr(GST_ADDR_CONTROL, 8'h47);
        src.pulses(3, 1);
        rchk("comparator", GST_ADDR_COUNT_LOW, 13);
        wr(GST_ADDR_CONTROL, 8'h00);
        wr(GST_ADDR_ENABLES, 8'h00);
        $display("t_ext done");
    endtask
    task automatic t_wake;
        wr(GST_ADDR_COUNT_LOW, 8'hFF);
        wr(GST_ADDR_COUNT_HI, 8'hFF);
        sleep <= 1'b1;
        src.use_xtal <= 1'b1;
        wr(GST_ADDR_CONTROL, 8'h0F);
        @(negedge clk);
        chk("osc en", 1, osc);
        src.pulses(2, 1);
        chk("wakeups", 1, wakes);
        rchk("asleep", GST_ADDR_COUNT_HI, 0);
        sleep <= 1'b0;
        wr(GST_ADDR_CONTROL, 8'h00);
        $display("t_wake done");
    endtask
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst     = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        sleep   = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_timer();
        t_ovf();
        t_ext();
        t_wake();
        conclude();
    end
    // whole run is near 1400 cycles; this cuts a hang well beyond that
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end
endmodule
